// File: src/shb_pkg.sv
// package: constants and types for the sram style host bus port
package shb_pkg;
    localparam int          SHB_ADDR_W       = 7;
    localparam int          SHB_BUS_W        = 16;
    localparam int          SHB_WORD_W       = 32;
    localparam int          SHB_REG_IDX_W    = 6;
    localparam int          SHB_FIFO_FLD_LSB = 2;
    // bus addresses 0x00..0x0F (low 8 words) map to the data fifos
    localparam logic [6:0]  SHB_FIFO_TOP     = 7'h0F;
    // within the fifo window, the access direction picks tx (write) / rx (read) area
    localparam logic [6:0]  SHB_ENDIAN_TEST  = 7'h32;
    localparam logic [31:0] SHB_ENDIAN_VALUE = 32'h87654321;
    localparam logic        SHB_IRQ_POL_RST  = 1'b0;
    localparam logic        SHB_IRQ_OD_RST   = 1'b0;
    localparam logic        SHB_WAKE_POL_RST = 1'b1;
    localparam logic        SHB_WAKE_OD_RST  = 1'b0;

    typedef enum logic [1:0]
    {
        SHB_TGT_NONE,
        SHB_TGT_REG,
        SHB_TGT_TXF,
        SHB_TGT_RXF
    } shb_tgt_type;

    typedef enum
    {
        SHB_IDLE,
        SHB_RD,
        SHB_WR
    } shb_state_type;
endpackage

// File: src/shb_half_if.sv
// interface: pin level output pair between top and pin driver
`timescale 1ns/1ps
`default_nettype none
interface shb_pin_if;
    logic level;
    logic pol;
    logic od;
    logic pin_out;
    logic pin_oe_n;
    modport ctl (output level, output pol, output od);
    modport drv (input level, input pol, input od,
                 output pin_out, output pin_oe_n);
endinterface
`default_nettype wire

// File: src/shb_pin_drv.sv
// module: programmable polarity and push-pull or open-drain output
`timescale 1ns/1ps
`default_nettype none
module shb_pin_drv
    import shb_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    shb_pin_if.drv    pin
);
    wire active_level = pin.level ? pin.pol : ~pin.pol;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin.pin_out  <= 1'b0;
            pin.pin_oe_n <= 1'b1;
        end
        else if (pin.od)
        begin
            // open drain drives only a low level; a high level floats
            pin.pin_out  <= 1'b0;
            pin.pin_oe_n <= active_level;
        end
        else
        begin
            pin.pin_out  <= active_level;
            pin.pin_oe_n <= 1'b0;
        end
    end

    a_od_never_high: assert property (@(posedge clk) disable iff (!resetn)
        $past(pin.od) && !pin.pin_oe_n |-> !pin.pin_out) // RL10
        else $error("open drain pin driven high");
    c_od_asserted: cover property (@(posedge clk) disable iff (!resetn)
        pin.od && !pin.pin_oe_n);
endmodule
`default_nettype wire

// File: src/shb_host_port.sv
// module: sram style host bus slave port with 16 to 32 bit conversion
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RL1] acts as asynchronous sram slave; host starts all programmed io
// [RL2] 16-bit external transfers converted to 32-bit internal words
// [RL3] big-endian setting swaps byte lanes on register path only
// [RL4] 7-bit word address selects a register, tx fifo or rx fifo
// [RL5] read with read strobe low; data driven only with chip select
// [RL6] write with write strobe and chip select low; data captured then
// [RL7] strobes ignored while chip select is high
// [RL8] fifo select high forces fifo access, upper address ignored
// [RL9] qualified write cycle leaves reduced power state
// [RL10] one interrupt output, programmable polarity, sources and type
// [RL11] separate wake output asserted on a wake event
// [RL12] after reset or wake a read must precede writes taking effect
// [RL13] host wakes device by writing the endian test register
// [RL14] a 32-bit word is two halves; address bit 0 picks half
module shb_host_port
    import shb_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [SHB_ADDR_W-1:0] addr,
    input  wire logic [SHB_BUS_W-1:0]  data_in,
    output logic      [SHB_BUS_W-1:0]  data_out,
    output logic                       data_oe_n,
    input  wire logic                  read_strobe_n,
    input  wire logic                  write_strobe_n,
    input  wire logic                  chip_select_n,
    input  wire logic                  fifo_select,
    input  wire logic                  big_endian,
    input  wire logic                  sleep_req,
    output logic                       reduced_power,
    input  wire logic                  irq_pol,
    input  wire logic                  irq_od,
    input  wire logic [7:0]            irq_sources,
    input  wire logic [7:0]            irq_enable,
    output logic                       irq_out,
    output logic                       irq_oe_n,
    input  wire logic                  wake_event,
    input  wire logic                  wake_pol,
    input  wire logic                  wake_od,
    output logic                       wake_event_out,
    output logic                       wake_oe_n,
    output logic [SHB_REG_IDX_W-1:0]   reg_index,
    output logic [SHB_WORD_W-1:0]      reg_wdata,
    output logic                       reg_wr,
    output logic                       reg_rd,
    input  wire logic [SHB_WORD_W-1:0] reg_rdata,
    output logic [SHB_WORD_W-1:0]      txf_wdata,
    output logic                       txf_wr,
    input  wire logic [SHB_WORD_W-1:0] rxf_rdata,
    output logic                       rxf_rd,
    output logic                       writes_armed
);
    function automatic logic [31:0] lane_swap(input logic [31:0] w,
                                              input logic        be);
        lane_swap = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction

    function automatic shb_tgt_type decode(input logic [6:0] a,
                                           input logic       fsel,
                                           input logic       is_wr);
        if (fsel || a <= SHB_FIFO_TOP)
            decode = is_wr ? SHB_TGT_TXF : SHB_TGT_RXF;
        else
            decode = SHB_TGT_REG;
    endfunction

    shb_state_type state;
    shb_state_type next_state;
    logic [15:0] low_half;
    logic [31:0] rd_word;
    logic        armed;
    logic        sleep;
    logic        wake_latch;

    wire rd_act = !chip_select_n && !read_strobe_n; // RL5 RL7
    wire wr_act = !chip_select_n && !write_strobe_n; // RL6 RL7
    wire upper  = addr[0]; // RL14
    // upper address bits are dropped under fifo select
    wire [6:0] eff_addr = fifo_select ? {5'h00, addr[1:0]} : addr; // RL8
    shb_tgt_type rd_tgt;
    shb_tgt_type wr_tgt;
    assign rd_tgt = decode(eff_addr, fifo_select, 1'b0); // RL4
    assign wr_tgt = decode(eff_addr, fifo_select, 1'b1); // RL4
    wire rd_start = rd_act && state == SHB_IDLE;
    wire wr_start = wr_act && state == SHB_IDLE;
    wire wr_ok    = wr_start && armed && !sleep; // RL12
    wire [31:0] full_word = {data_in, low_half}; // RL2
    wire [31:0] reg_word  = lane_swap(full_word, big_endian); // RL3
    wire [31:0] reg_rd_sw = lane_swap(reg_rdata, big_endian); // RL3
    wire [31:0] fetch     = rd_tgt == SHB_TGT_REG ? reg_rd_sw : rxf_rdata;
    wire [15:0] rd_half   = upper ? rd_word[31:16] : rd_word[15:0]; // RL14

    always_comb
    begin
        next_state = state;
        unique case (state)
            SHB_IDLE: if (rd_act) next_state = SHB_RD;
                      else if (wr_act) next_state = SHB_WR;
            SHB_RD:   if (!rd_act) next_state = SHB_IDLE;
            SHB_WR:   if (!wr_act) next_state = SHB_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state <= SHB_IDLE;
        else
            state <= next_state; // RL1
    end

    // read word latched at the low half, so both halves are coherent
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rd_word <= 32'h00000000;
        else if (rd_start && !upper)
            rd_word <= fetch; // RL2
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            data_out <= 16'h0000;
        else if (rd_act)
            data_out <= (rd_start && !upper) ? fetch[15:0] : rd_half;
    end

    assign data_oe_n = !(rd_act && state == SHB_RD); // RL5

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            low_half <= 16'h0000;
        else if (wr_ok && !upper)
            low_half <= data_in; // RL6 RL14
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_wr    <= 1'b0;
            txf_wr    <= 1'b0;
            reg_rd    <= 1'b0;
            rxf_rd    <= 1'b0;
            reg_index <= 6'h00;
            reg_wdata <= 32'h00000000;
            txf_wdata <= 32'h00000000;
        end
        else
        begin
            reg_wr <= wr_ok && upper && wr_tgt == SHB_TGT_REG;
            txf_wr <= wr_ok && upper && wr_tgt == SHB_TGT_TXF;
            // pop on the upper half read completes the word
            reg_rd <= rd_start && upper && rd_tgt == SHB_TGT_REG;
            rxf_rd <= rd_start && upper && rd_tgt == SHB_TGT_RXF;
            if (rd_start || wr_start)
                reg_index <= eff_addr[6:1];
            if (wr_ok && upper)
            begin
                reg_wdata <= reg_word;
                txf_wdata <= full_word;
            end
        end
    end

    // writes are held off until a read after reset or wakeup
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            armed <= 1'b0;
        else if (sleep && wr_start)
            armed <= 1'b0; // RL12
        else if (rd_start && !sleep)
            armed <= 1'b1; // RL12
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sleep <= 1'b0;
        else if (wr_start)
            sleep <= 1'b0; // RL9 RL13
        else if (sleep_req)
            sleep <= 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wake_latch <= 1'b0;
        else if (wake_event)
            wake_latch <= 1'b1; // RL11
        else if (wr_start && sleep)
            wake_latch <= 1'b0;
    end

    assign reduced_power = sleep;
    assign writes_armed  = armed;

    shb_pin_if irq_if ();
    shb_pin_if wake_if ();
    assign irq_if.level  = |(irq_sources & irq_enable); // RL10
    assign irq_if.pol    = irq_pol;
    assign irq_if.od     = irq_od;
    assign wake_if.level = wake_latch; // RL11
    assign wake_if.pol   = wake_pol;
    assign wake_if.od    = wake_od;
    assign irq_out        = irq_if.pin_out;
    assign irq_oe_n       = irq_if.pin_oe_n;
    assign wake_event_out = wake_if.pin_out;
    assign wake_oe_n      = wake_if.pin_oe_n;

    shb_pin_drv u_irq_drv (.clk(clk), .resetn(resetn), .pin(irq_if.drv));
    shb_pin_drv u_wake_drv (.clk(clk), .resetn(resetn), .pin(wake_if.drv));

    a_no_drive_idle: assert property (@(posedge clk) disable iff (!resetn)
        chip_select_n |-> data_oe_n) // RL7
        else $error("data driven without chip select");
    a_drive_in_read: assert property (@(posedge clk) disable iff (!resetn)
        !data_oe_n |-> rd_act) // RL5
        else $error("data driven outside read");
    a_write_pulse: assert property (@(posedge clk) disable iff (!resetn)
        wr_ok && upper && wr_tgt == SHB_TGT_REG |=> reg_wr ##1 !reg_wr) // RL6
        else $error("register write not one pulse");
    a_fifo_forced: assert property (@(posedge clk) disable iff (!resetn)
        fifo_select && wr_ok && upper |=> txf_wr && !reg_wr) // RL8
        else $error("fifo select write missed fifo");
    a_wake_write: assert property (@(posedge clk) disable iff (!resetn)
        sleep && wr_start |=> !reduced_power) // RL9
        else $error("write did not wake device");
    a_arm_needed: assert property (@(posedge clk) disable iff (!resetn)
        !armed |=> !reg_wr && !txf_wr) // RL12
        else $error("write took effect before read");
    a_swap_lanes: assert property (@(posedge clk) disable iff (!resetn)
        reg_wr && $past(big_endian) |->
        reg_wdata[7:0] == $past(data_in[15:8])) // RL3
        else $error("big endian lanes not swapped");
    a_wake_out: assert property (@(posedge clk) disable iff (!resetn)
        wake_event && !wake_od |-> ##2 wake_event_out == wake_pol) // RL11
        else $error("wake output not asserted");
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        |(irq_sources & irq_enable) && !irq_od |=>
        irq_out == $past(irq_pol)) // RL10
        else $error("interrupt output wrong level");

    c_reg_write: cover property (@(posedge clk) disable iff (!resetn)
        reg_wr);
    c_fifo_read: cover property (@(posedge clk) disable iff (!resetn)
        rxf_rd);
    c_wakeup: cover property (@(posedge clk) disable iff (!resetn)
        sleep ##1 !sleep);
endmodule
`default_nettype wire

// File: sim/shb_host_model.sv
// host cpu model driving the sram style strobes of the port
`timescale 1ns/1ps
`default_nettype none
module shb_host_model
    import shb_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [SHB_BUS_W-1:0]  data_out,
    input  wire logic                  data_oe_n,
    output logic      [SHB_ADDR_W-1:0] addr,
    output logic      [SHB_BUS_W-1:0]  data_in,
    output logic                       read_strobe_n,
    output logic                       write_strobe_n,
    output logic                       chip_select_n
);
    initial
    begin
        addr = 7'h00;
        data_in = 16'hFFFF;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
    end

    // every transfer is started here; an idle edge separates accesses
    task automatic rd16(input logic [6:0] a, input logic cs,
                        output logic [15:0] d, output logic got);
        int i;
        got = 1'b0;
        d = 16'h0000;
        @(posedge clk);
        addr <= a;
        chip_select_n <= ~cs;
        read_strobe_n <= 1'b0;
        for (i = 0; i < 6 && !got; i++)
        begin
            @(posedge clk);
            if (data_oe_n === 1'b0)
            begin
                d = data_out;
                got = 1'b1;
            end
        end
        read_strobe_n <= 1'b1;
        chip_select_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic wr16(input logic [6:0] a, input logic cs,
                        input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        data_in <= d;
        chip_select_n <= ~cs;
        write_strobe_n <= 1'b0;
        repeat (2) @(posedge clk);
        write_strobe_n <= 1'b1;
        chip_select_n <= 1'b1;
        // a released bus must not keep showing the old value
        data_in <= ~d;
        repeat (2) @(posedge clk);
    endtask

    // low half first, then the upper half at the adjacent address
    task automatic rd32(input logic [6:0] a, output logic [31:0] w);
        logic g;
        rd16({a[6:1], 1'b0}, 1'b1, w[15:0], g);
        rd16({a[6:1], 1'b1}, 1'b1, w[31:16], g);
    endtask

    task automatic wr32(input logic [6:0] a, input logic [31:0] w);
        wr16({a[6:1], 1'b0}, 1'b1, w[15:0]);
        wr16({a[6:1], 1'b1}, 1'b1, w[31:16]);
    endtask
endmodule
`default_nettype wire

// File: sim/tb_sram_style_host_bus_port.sv
// self-checking bench for the sram style host bus port
`timescale 1ns/1ps
`default_nettype none
module tb_sram_style_host_bus_port
    import shb_pkg::*;
;
    logic        clk, resetn, fifo_select, big_endian, sleep_req;
    logic        irq_pol, irq_od, wake_event, wake_pol, wake_od;
    logic        data_oe_n, read_strobe_n, write_strobe_n, chip_select_n;
    logic        reduced_power, irq_out, irq_oe_n, wake_event_out;
    logic        wake_oe_n, reg_wr, reg_rd, txf_wr, rxf_rd, writes_armed;
    logic [7:0]  irq_sources, irq_enable;
    logic [6:0]  addr;
    logic [15:0] data_in, data_out;
    logic [5:0]  reg_index, last_i;
    logic [31:0] reg_wdata, txf_wdata, last_w, last_t, w;
    logic [31:0] reg_rdata = 32'h11223344;
    logic [31:0] rxf_rdata = 32'h5A6B7C8D;
    int          errors = 0, n_checks = 0, cyc = 0;
    int          n_rw = 0, n_rd = 0, n_tw = 0, n_rf = 0;

    shb_host_port shb_host_port_inst (.clk(clk), .resetn(resetn),
        .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n),
        .fifo_select(fifo_select), .big_endian(big_endian),
        .sleep_req(sleep_req), .reduced_power(reduced_power),
        .irq_pol(irq_pol), .irq_od(irq_od), .irq_sources(irq_sources),
        .irq_enable(irq_enable), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
        .wake_event(wake_event), .wake_pol(wake_pol), .wake_od(wake_od),
        .wake_event_out(wake_event_out), .wake_oe_n(wake_oe_n),
        .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txf_wdata(txf_wdata),
        .txf_wr(txf_wr), .rxf_rdata(rxf_rdata), .rxf_rd(rxf_rd),
        .writes_armed(writes_armed));

    shb_host_model shb_host_model_inst (.clk(clk), .data_out(data_out),
        .data_oe_n(data_oe_n), .addr(addr), .data_in(data_in),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chip_select_n(chip_select_n));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // counts back-end pulses and keeps what they carried
    always @(posedge clk)
    begin
        cyc++;
        if (reg_wr === 1'b1)
        begin
            n_rw++;
            last_i = reg_index;
            last_w = reg_wdata;
        end
        if (txf_wr === 1'b1)
        begin
            n_tw++;
            last_t = txf_wdata;
        end
        n_rd += (reg_rd === 1'b1);
        n_rf += (rxf_rd === 1'b1);
        if (cyc == 3000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s %h/%h", $time, what, seen, exp);
        end
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_arm_and_reg;
        shb_host_model_inst.wr32(7'h2A, 32'hDEADBEEF);
        chk(n_rw, 0, "write before read");
        shb_host_model_inst.rd32(7'h22, w);
        chk(w, 32'h11223344, "reg read");
        chk(n_rd, 1, "reg pop");
        chk(writes_armed, 1'b1, "armed");
        shb_host_model_inst.wr32(7'h2A, 32'hA1B2C3D4);
        chk({n_rw[1:0], last_i}, {2'h1, 6'h15}, "reg index");
        chk(last_w, 32'hA1B2C3D4, "reg write");
        $display("done arm and register");
    endtask

    task automatic t_endian_fifo;
        @(posedge clk);
        big_endian <= 1'b1;
        shb_host_model_inst.rd32(7'h22, w);
        chk(w, 32'h44332211, "be read");
        shb_host_model_inst.wr32(7'h2A, 32'hA1B2C3D4);
        chk(last_w, 32'hD4C3B2A1, "be write");
        shb_host_model_inst.wr32(7'h04, 32'h01020304);
        chk(last_t, 32'h01020304, "low window tx");
        @(posedge clk);
        fifo_select <= 1'b1;
        shb_host_model_inst.wr32(7'h7E, 32'h13572468);
        chk(last_t, 32'h13572468, "fifo sel tx");
        chk(reg_index, 6'h01, "fifo sel index");
        chk({n_rw[3:0], n_tw[3:0]}, 8'h22, "fifo sel count");
        shb_host_model_inst.rd32(7'h6E, w);
        chk(w, 32'h5A6B7C8D, "fifo sel rx");
        chk(n_rf, 1, "rx pop");
        @(posedge clk);
        fifo_select <= 1'b0;
        big_endian <= 1'b0;
        $display("done endian and fifo");
    endtask

    task automatic t_no_cs;
        logic [15:0] d;
        logic        g;
        shb_host_model_inst.rd16(7'h22, 1'b0, d, g);
        chk(g, 1'b0, "read without cs");
        shb_host_model_inst.wr16(7'h2A, 1'b0, 16'h1111);
        shb_host_model_inst.wr16(7'h2B, 1'b0, 16'h2222);
        chk(n_rw, 2, "write without cs");
        $display("done chip select");
    endtask

    task automatic t_sleep_wake;
        @(posedge clk);
        sleep_req <= 1'b1;
        wake_event <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        wake_event <= 1'b0;
        settle();
        chk({reduced_power, wake_event_out, wake_oe_n}, 3'h6, "sleep");
        shb_host_model_inst.wr16(SHB_ENDIAN_TEST, 1'b1, 16'h4321);
        settle();
        chk({reduced_power, writes_armed}, 2'h0, "woken");
        chk({n_rw[1:0], wake_event_out}, 3'h4, "wake clear");
        wake_pol <= 1'b0;
        wake_od <= 1'b1;
        settle();
        chk({wake_event_out, wake_oe_n}, 2'h1, "wake od idle");
        $display("done sleep and wake");
    endtask

    task automatic t_irq;
        @(posedge clk);
        irq_sources <= 8'h04;
        irq_enable <= 8'h04;
        irq_pol <= 1'b1;
        settle();
        chk({irq_out, irq_oe_n}, 2'h2, "irq high");
        irq_pol <= 1'b0;
        settle();
        chk({irq_out, irq_oe_n}, 2'h0, "irq low");
        irq_enable <= 8'h00;
        settle();
        chk({irq_out, irq_oe_n}, 2'h2, "irq masked");
        irq_od <= 1'b1;
        settle();
        chk(irq_oe_n, 1'b1, "od idle");
        irq_enable <= 8'h04;
        settle();
        chk({irq_out, irq_oe_n}, 2'h0, "od active");
        $display("done interrupt");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        {resetn, fifo_select, big_endian, sleep_req, wake_event} = 5'h00;
        {irq_pol, irq_od, wake_pol, wake_od} = 4'h2;
        {irq_sources, irq_enable} = 16'h0000;
        repeat (8) @(posedge clk);
        chk({data_oe_n, writes_armed, reduced_power}, 3'h4, "reset");
        resetn <= 1'b1;
        t_arm_and_reg();
        t_endian_fifo();
        t_no_cs();
        t_sleep_wake();
        t_irq();
        report_and_stop();
    end
endmodule
`default_nettype wire
